// ### core/start_jump_pkg.sv
// Shared encodings, field positions and carriers for the start-jump decoder
package start_jump_pkg;

    localparam int unsigned INSTR_W = 16;
    localparam int unsigned START_W = 6;
    localparam int unsigned OFFSET_W = 5;
    localparam int unsigned JREG_N = 2;
    localparam int unsigned CODE_ADDR_W = 10;

    // Major opcode field, bits 15..11
    localparam int unsigned OPC_HI = 15;
    localparam int unsigned OPC_LO = 11;
    localparam logic [4:0] OPC_ABS_START = 5'h07;
    localparam logic [4:0] OPC_REL_START = 5'h01;

    // Minor opcode of the absolute form, bits 3..0
    localparam int unsigned SUB_HI = 3;
    localparam int unsigned SUB_LO = 0;
    localparam logic [3:0] SUB_ABS_START = 4'h1;

    // Start selection mask, bits 10..5
    localparam int unsigned SEL_HI = 10;
    localparam int unsigned SEL_LO = 5;

    // Jump register select (absolute) and offset (relative)
    localparam int unsigned JREG_BIT = 4;
    localparam int unsigned OFS_HI = 4;
    localparam int unsigned OFS_LO = 0;

    localparam logic [START_W-1:0] START_NONE = 6'h00;

    typedef struct packed {
        logic valid;
        logic [INSTR_W-1:0] word;
        logic [CODE_ADDR_W-1:0] addr;
    } instr_req_s;

    typedef struct packed {
        logic valid;
        logic hit_abs;
        logic hit_rel;
        logic taken;
        logic [CODE_ADDR_W-1:0] next_addr;
    } fetch_res_s;

    typedef enum logic [1:0] {
        KIND_OTHER,
        KIND_ABS,
        KIND_REL
    } jump_kind_e;

endpackage

// ### core/start_condition_eval.sv
// Compares the latched start inputs with an instruction's start mask
`timescale 1ns/10ps
module start_condition_eval #(
    parameter int unsigned WIDTH = 6
) (
    input wire logic [WIDTH-1:0] mask_i,
    input wire logic [WIDTH-1:0] latched_i,
    output logic met_o
);
    initial begin
        if (WIDTH < 1) begin
            $error("start_condition_eval: WIDTH must be at least 1");
        end
    end

    // Mask bit n names start input n+1; the condition is the exact latched
    // set, so an all-zero mask asks for no start latched at all
    assign met_o = (latched_i == mask_i);
endmodule

// ### core/start_condition_jump_decode.sv
// Decode and execute of the two start-condition jumps of the sequencer
`timescale 1ns/10ps
module start_condition_jump_decode (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input start_jump_pkg::instr_req_s instr_i,
    input wire logic [start_jump_pkg::START_W-1:0] start_latched_i,
    input wire logic [start_jump_pkg::CODE_ADDR_W-1:0] jump_register_set_i
        [start_jump_pkg::JREG_N],
    output start_jump_pkg::fetch_res_s result_o
);
    import start_jump_pkg::*;

    initial begin
        if (CODE_ADDR_W <= OFFSET_W) begin
            $error("Code address must be wider than the relative offset");
        end
        if (JREG_N != 2) begin
            $error("Jump register select is one bit: exactly two registers");
        end
    end

    // Field extraction
    wire logic [4:0] opcode = instr_i.word[OPC_HI:OPC_LO];
    wire logic [3:0] subcode = instr_i.word[SUB_HI:SUB_LO];
    wire logic [START_W-1:0] start_mask_select = instr_i.word[SEL_HI:SEL_LO];
    wire logic jump_register_operand = instr_i.word[JREG_BIT];
    wire logic [OFFSET_W-1:0] offset = instr_i.word[OFS_HI:OFS_LO];

    // Instruction recognition
    wire logic is_abs = (opcode == OPC_ABS_START)
        && (subcode == SUB_ABS_START);
    wire logic is_rel = (opcode == OPC_REL_START);
    jump_kind_e kind;
    assign kind = is_abs ? KIND_ABS : (is_rel ? KIND_REL : KIND_OTHER);

    // Start condition
    logic cond_met;
    start_condition_eval #(
        .WIDTH(START_W)
    ) u_cond (
        .mask_i(start_mask_select),
        .latched_i(start_latched_i),
        .met_o(cond_met)
    );

    // Absolute target: the whole register, no relation to the current
    // address, so any code location is reachable
    wire logic [CODE_ADDR_W-1:0] abs_target =
        jump_register_set_i[jump_register_operand];

    // Sign-extended offset; the sum wraps modulo the code memory size,
    // which matches a fixed-width program counter
    wire logic [CODE_ADDR_W-1:0] offset_ext =
        {{(CODE_ADDR_W-OFFSET_W){offset[OFFSET_W-1]}}, offset};
    wire logic [CODE_ADDR_W-1:0] rel_target =
        CODE_ADDR_W'(instr_i.addr + offset_ext);
    wire logic [CODE_ADDR_W-1:0] seq_target =
        CODE_ADDR_W'(instr_i.addr + 1'b1);

    // Next-address selection
    logic taken;
    logic [CODE_ADDR_W-1:0] target;
    always_comb begin
        taken = 1'b0;
        target = seq_target;
        case (kind)
            KIND_ABS: begin
                taken = cond_met;
                if (cond_met) begin
                    target = abs_target;
                end
            end
            KIND_REL: begin
                taken = cond_met;
                if (cond_met) begin
                    target = rel_target;
                end
            end
            default: begin
                taken = 1'b0;
                target = seq_target;
            end
        endcase
    end

    fetch_res_s res_d;
    fetch_res_s res_q;
    assign res_d.valid = instr_i.valid;
    assign res_d.hit_abs = instr_i.valid && is_abs;
    assign res_d.hit_rel = instr_i.valid && is_rel;
    assign res_d.taken = instr_i.valid && taken;
    assign res_d.next_addr = instr_i.valid ? target : res_q.next_addr;

    // One registered result per presented instruction
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            res_q <= '0;
        end else begin
            res_q <= res_d;
        end
    end

    assign result_o = res_q;
endmodule

// ### tb/start_jump_props.sv
// Port assertions for the start jump decoder
`timescale 1ns/10ps
module start_jump_props (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input start_jump_pkg::instr_req_s instr_i,
    input wire logic [5:0] start_latched_i,
    input wire logic [9:0] jump_register_set_i [2],
    input start_jump_pkg::fetch_res_s result_o
);
    import start_jump_pkg::*;
    wire fetch_res_s r = result_o;
    wire logic [15:0] w = instr_i.word;
    wire v = instr_i.valid;
    wire ab = w[15:11] == OPC_ABS_START && w[3:0] == SUB_ABS_START;
    wire rl = w[15:11] == OPC_REL_START;
    wire hit = (ab || rl) && start_latched_i == w[10:5];
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    a_result_pulse: assert property (r.valid == $past(v))
        else $error("pulse");
    a_idle_quiet: assert property (!v |=> !r.taken && !r.hit_abs && !r.hit_rel)
        else $error("idle");
    a_abs_decode: assert property (v |=> r.hit_abs == $past(ab))
        else $error("abs");
    a_rel_decode: assert property (v |=> r.hit_rel == $past(rl))
        else $error("rel");
    a_taken_cond: assert property (v |=> r.taken == $past(hit))
        else $error("taken");
    a_abs_target: assert property (v && ab && hit |=>
        r.next_addr == $past(jump_register_set_i[w[4]])) else $error("far");
    a_rel_target: assert property (v && rl && hit |=>
        r.next_addr == $past(instr_i.addr + {{5{w[4]}}, w[4:0]}))
        else $error("near");
    a_seq_next: assert property (v && !hit |=>
        r.next_addr == $past(instr_i.addr) + 10'h001) else $error("seq");
    c_abs: cover property (v && ab && hit);
    c_rel: cover property (v && rl && hit);
    c_miss: cover property (v && !hit);
endmodule
bind start_condition_jump_decode start_jump_props props_i (.core_clk_i,
    .rstn_i, .instr_i, .start_latched_i, .jump_register_set_i, .result_o);

// ### tb/start_condition_jump_decode_tb.sv
// Directed bench for the start jump decoder
`timescale 1ns/10ps
module start_condition_jump_decode_tb;
    import start_jump_pkg::*;
    logic core_clk_i = 1'h0, rstn_i = 1'h0;
    instr_req_s instr = '0;
    logic [5:0] lat = 6'h00;
    logic [9:0] jr [2] = '{10'h000, 10'h000};
    fetch_res_s res;
    int err_total = 0, compares = 0, cyc = 0;
    start_condition_jump_decode dut (.core_clk_i, .rstn_i, .instr_i(instr),
        .start_latched_i(lat), .jump_register_set_i(jr), .result_o(res));
    always #5 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) if (++cyc == 500) close_out(1);
    task close_out(input int hung);
        err_total += hung;
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task check(input logic [13:0] seen, input logic [13:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t %h %h", $time, seen, exp);
        end
    endtask
    // Flags f: valid, hit_abs, hit_rel, taken; sums wrap at 10 bits
    task go(input logic [15:0] w, input logic [9:0] a, input logic [5:0] l,
            input logic [3:0] f, input logic [9:0] n);
        @(posedge core_clk_i);
        instr <= '{1'h1, w, a};
        lat <= l;
        @(posedge core_clk_i);
        instr.valid <= 1'h0;
        #1 check(res, {f, n});
        // Flags last one cycle, the address stands until the next result
        @(posedge core_clk_i);
        #1 check(res, {4'h0, n});
    endtask
    task t_abs;
        jr <= '{10'h015, 10'h3FF};
        go(16'h3FF1, 10'h004, 6'h3F, 4'hD, 10'h3FF);
        go(16'h3821, 10'h3FF, 6'h01, 4'hD, 10'h015);
        go(16'h3825, 10'h020, 6'h01, 4'h8, 10'h021);
    endtask
    task t_rel;
        go(16'h0810, 10'h003, 6'h00, 4'hB, 10'h3F3);
        go(16'h0C0F, 10'h3F5, 6'h20, 4'hB, 10'h004);
    endtask
    task t_miss;
        go(16'h3821, 10'h010, 6'h02, 4'hC, 10'h011);
        go(16'h0FE1, 10'h3FF, 6'h3E, 4'hA, 10'h000);
    endtask
    initial begin
        repeat (8) @(posedge core_clk_i);
        #1 check(res, 14'h0000);
        @(negedge core_clk_i);
        @(posedge core_clk_i);
        rstn_i <= 1'h1;
        t_abs;
        t_rel;
        t_miss;
        close_out(0);
    end
endmodule
